// ### uss_shift_register.sv
/*
  Universal shift/storage register top: pin-level mode control, the
  shared parallel bus with its drivers, cascade taps, and an AXI4-Lite
  register slave for soft clear, driver blocking and status.
  Assumes every pin input, shift_clock included, is synchronous to
  clk_in and that shift_clock changes no faster than every other cycle.
*/
`timescale 1ns/1ps
module uss_shift_register
  import uss_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  // Device pins
  input wire logic shift_clock_in,
  input wire logic master_reset_n_in,
  input wire logic mode_select_hi_in,
  input wire logic mode_select_lo_in,
  input wire logic right_serial_in,
  input wire logic left_serial_in,
  input wire logic output_enable_a_n_in,
  input wire logic output_enable_b_n_in,
  input wire logic [USS_STAGES-1:0] parallel_bus_in,
  output logic [USS_STAGES-1:0] parallel_bus_out,
  output logic [USS_STAGES-1:0] parallel_bus_oe_out,
  output logic first_stage_tap_out,
  output logic last_stage_tap_out,
  // AXI4-Lite slave
  input wire logic [USS_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [USS_DATA_W-1:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [USS_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [USS_DATA_W-1:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);

  // ==========================================================
  // Declarations
  logic shift_clock_prev;
  logic step;
  logic clear_now;
  logic reset_active;
  logic drivers_on;
  uss_mode_e mode;
  logic [USS_STAGES-1:0] stages;
  logic drive_block;
  logic soft_clear;
  logic [31:0] edge_count;
  logic aw_held;
  logic [USS_ADDR_W-1:0] aw_addr;
  logic w_held;
  logic [USS_DATA_W-1:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic do_read;
  logic wr_ctrl;
  logic wr_edges;
  logic wr_known;
  logic wr_state;
  logic rd_ctrl;
  logic rd_state;
  logic rd_edges;
  logic [USS_ADDR_W-3:0] aw_index;
  logic [USS_ADDR_W-3:0] ar_index;
  logic aw_take;
  logic w_take;
  logic ctrl_write;
  logic edge_clear;
  logic pins_release;
  logic load_release;
  logic [1:0] next_bresp;
  uss_state_s state_word;
  logic [USS_DATA_W-1:0] next_rdata;
  logic [1:0] next_rresp;

  // ==========================================================
  // Mode decode
  always_comb begin
    unique case ({mode_select_hi_in, mode_select_lo_in})
      2'h0: mode = USS_MODE_HOLD;
      2'h1: mode = USS_MODE_RIGHT;
      2'h2: mode = USS_MODE_LEFT;
      2'h3: mode = USS_MODE_LOAD;
    endcase
  end

  // ==========================================================
  // Shift clock edge
  // Sampled, not used as a clock: one domain, and the edge is seen
  // in the clk_in cycle in which shift_clock rises.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      shift_clock_prev <= 1'b0;
    end else begin
      shift_clock_prev <= shift_clock_in;
    end
  end

  // Reset level matches the idle pin, so no false edge follows reset
  assign step = shift_clock_in && !shift_clock_prev;

  // ==========================================================
  // Clearing
  assign reset_active = !master_reset_n_in;
  // Reset overrides selects and clock, also while drivers are off
  assign clear_now = reset_active || soft_clear;

  // ==========================================================
  // Storage stages
  // Master reset enters as a clear, so a step in that cycle is lost
  uss_stage_core u_core (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .clear_in(clear_now),
    .step_in(step),
    .mode_in(mode),
    .right_serial_in(right_serial_in),
    .left_serial_in(left_serial_in),
    .load_data_in(parallel_bus_in),
    .stages_out(stages)
  );

  // ==========================================================
  // Pin outputs
  // Masking by the reset level makes the clear visible at once,
  // before the flops themselves are cleared on the next clk_in.
  assign first_stage_tap_out = stages[0] && master_reset_n_in;
  assign last_stage_tap_out =
    stages[USS_STAGES-1] && master_reset_n_in;
  assign parallel_bus_out =
    master_reset_n_in ? stages : '0;

  assign pins_release = output_enable_a_n_in || output_enable_b_n_in;
  // Load release hangs on the selects alone, so outside load data
  // never fights the stage drivers, whatever the enables say.
  assign load_release = mode == USS_MODE_LOAD;

  always_comb begin
    drivers_on = 1'b1;
    if (pins_release) begin
      drivers_on = 1'b0;
    end
    if (load_release) begin
      drivers_on = 1'b0;
    end
    // Software override; it only ever turns drivers off
    if (drive_block) begin
      drivers_on = 1'b0;
    end
  end

  assign parallel_bus_oe_out = {USS_STAGES{drivers_on}};

  // ==========================================================
  // Edge counter
  // Clear wins, but an edge in the clearing write's cycle counts as one.
  // Edges count in every mode, hold and master reset included.
  assign edge_clear = do_write && wr_edges;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      edge_count <= USS_EDGES_RST;
    end else if (edge_clear) begin
      edge_count <= step ? 32'h0000_0001 : 32'h0000_0000;
    end else if (step) begin
      edge_count <= edge_count + 32'h0000_0001;
    end
  end

  // ==========================================================
  // AXI write channel
  // Each half is parked until the other arrives, in either order.
  assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
  assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;
  assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
  assign w_take = s_axi_wvalid_in && s_axi_wready_out;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_in;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_in;
      w_strb <= s_axi_wstrb_in;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  assign do_write = aw_held && w_held;

  // ==========================================================
  // Address decode
  // Byte lanes below the word are ignored: every register is one word.
  assign aw_index = aw_addr[USS_ADDR_W-1:2];
  assign ar_index = s_axi_araddr_in[USS_ADDR_W-1:2];
  assign wr_ctrl = aw_index == USS_OFS_CTRL[USS_ADDR_W-1:2];
  assign wr_state = aw_index == USS_OFS_STATE[USS_ADDR_W-1:2];
  assign wr_edges = aw_index == USS_OFS_EDGES[USS_ADDR_W-1:2];
  assign wr_known = wr_ctrl || wr_state || wr_edges;
  assign rd_ctrl = ar_index == USS_OFS_CTRL[USS_ADDR_W-1:2];
  assign rd_state = ar_index == USS_OFS_STATE[USS_ADDR_W-1:2];
  assign rd_edges = ar_index == USS_OFS_EDGES[USS_ADDR_W-1:2];
  assign next_bresp = wr_known ? USS_RESP_OKAY : USS_RESP_SLVERR;
  // Only the low byte lane holds control bits
  assign ctrl_write = do_write && wr_ctrl && w_strb[0];

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= USS_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= next_bresp;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // ==========================================================
  // Control register
  // Soft clear is a one-cycle pulse; it never reads back as set.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      drive_block <= USS_DRIVE_BLOCK_RST;
      soft_clear <= 1'b0;
    end else begin
      soft_clear <= 1'b0;
      if (ctrl_write) begin
        drive_block <= w_data[USS_CTRL_DRIVE_BLOCK];
        soft_clear <= w_data[USS_CTRL_SOFT_CLEAR];
      end
    end
  end

  // ==========================================================
  // AXI read channel
  assign s_axi_arready_out = !s_axi_rvalid_out;
  assign do_read = s_axi_arvalid_in && s_axi_arready_out;

  // A live snapshot of the pins; the read data register holds it
  always_comb begin
    state_word = '0;
    state_word.stages = master_reset_n_in ? stages : '0;
    state_word.mode = mode;
    state_word.drivers_on = drivers_on;
    state_word.reset_active = reset_active;
  end

  always_comb begin
    next_rdata = '0;
    next_rresp = USS_RESP_OKAY;
    if (rd_ctrl) begin
      next_rdata[USS_CTRL_DRIVE_BLOCK] = drive_block;
    end else if (rd_state) begin
      next_rdata = state_word;
    end else if (rd_edges) begin
      next_rdata = edge_count;
    end else begin
      next_rresp = USS_RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= '0;
      s_axi_rresp_out <= USS_RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= next_rdata;
      s_axi_rresp_out <= next_rresp;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

endmodule : uss_shift_register

// ### uss_pkg.sv
/*
  Shared constants and types for the universal shift/storage register:
  stage count, mode encoding, register offsets, field positions and
  reset values of the software-visible registers.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned offsets.
*/
// Operation
// - Eight edge-triggered storage stages, numbered 0 to 7.
// - Master reset low clears all stages at once, overriding clock and selects.
// - Outside reset, stages change only at a rising shift clock edge; the soft clear bit also empties them without one.
// - Both selects high: each rising edge loads bus line n into stage n.
// - Select hi low, lo high: shift right, serial in to stage 0.
// - Select hi high, lo low: shift left, serial in to stage 7.
// - Both selects low: contents held whatever the clock does.
// - Each stage drives its own bus line when its driver is enabled.
// - Either output enable high releases all eight bus lines.
// - Shift, hold, load and reset still work with drivers released.
// - Both selects high releases the bus drivers regardless of enables.
// - Stage 0 and stage 7 always driven on separate tap outputs.
package uss_pkg;

  // ==========================================================
  // Geometry
  localparam int USS_STAGES = 8;
  localparam int USS_ADDR_W = 8;
  localparam int USS_DATA_W = 32;

  // ==========================================================
  // Modes, in select order {hi, lo}
  typedef enum logic [1:0] {
    USS_MODE_HOLD,
    USS_MODE_RIGHT,
    USS_MODE_LEFT,
    USS_MODE_LOAD
  } uss_mode_e;

  // ==========================================================
  // Register offsets
  localparam logic [USS_ADDR_W-1:0] USS_OFS_CTRL = 8'h00;
  localparam logic [USS_ADDR_W-1:0] USS_OFS_STATE = 8'h04;
  localparam logic [USS_ADDR_W-1:0] USS_OFS_EDGES = 8'h08;

  // Control fields
  localparam int USS_CTRL_SOFT_CLEAR = 0;
  localparam int USS_CTRL_DRIVE_BLOCK = 1;
  localparam logic USS_DRIVE_BLOCK_RST = 1'b0;
  localparam logic [31:0] USS_EDGES_RST = 32'h0000_0000;

  // AXI responses
  localparam logic [1:0] USS_RESP_OKAY = 2'h0;
  localparam logic [1:0] USS_RESP_SLVERR = 2'h2;

  // ==========================================================
  // State register layout
  typedef struct packed {
    logic [19:0] zero;
    logic reset_active;
    logic drivers_on;
    logic [1:0] mode;
    logic [USS_STAGES-1:0] stages;
  } uss_state_s;

endpackage : uss_pkg

// ### uss_stage_core.sv
/*
  Eight-stage storage register with per-stage next-value selection
  for hold, shift right, shift left and parallel load.
  Assumes step_in is a one-cycle pulse marking a shift clock edge and
  clear_in a level that empties the stages.
*/
`timescale 1ns/1ps
module uss_stage_core
  import uss_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic clear_in,
  input wire logic step_in,
  input wire uss_mode_e mode_in,
  input wire logic right_serial_in,
  input wire logic left_serial_in,
  input wire logic [USS_STAGES-1:0] load_data_in,
  output logic [USS_STAGES-1:0] stages_out
);

  // ==========================================================
  // Neighbour chains
  logic [USS_STAGES-1:0] right_chain;
  logic [USS_STAGES-1:0] left_chain;
  logic [USS_STAGES-1:0] next_stages;

  assign right_chain = {stages_out[USS_STAGES-2:0], right_serial_in};
  assign left_chain = {left_serial_in, stages_out[USS_STAGES-1:1]};

  // ==========================================================
  // Per-stage selection
  for (genvar i = 0; i < USS_STAGES; i++) begin : g_stage
    logic stage_next;
    always_comb begin
      unique case (mode_in)
        USS_MODE_HOLD: stage_next = stages_out[i];
        USS_MODE_RIGHT: stage_next = right_chain[i];
        USS_MODE_LEFT: stage_next = left_chain[i];
        USS_MODE_LOAD: stage_next = load_data_in[i];
      endcase
    end
    assign next_stages[i] = stage_next;
  end

  // ==========================================================
  // Storage
  always_ff @(posedge clk_in) begin
    if (srst_in || clear_in) begin
      stages_out <= '0;
    end else if (step_in) begin
      stages_out <= next_stages;
    end
  end

endmodule : uss_stage_core

// ### uss_bus_partner.sv
/*
  Controlling logic's side of the shared parallel bus.
  Assumes all device output enable bits are equal.
*/
`timescale 1ns/1ps
module uss_bus_partner
  import uss_pkg::*;
(
  input wire logic clk_in,
  input wire logic [USS_STAGES-1:0] dev_data_in,
  input wire logic [USS_STAGES-1:0] dev_oe_in,
  input wire logic drive_in,
  input wire logic [USS_STAGES-1:0] data_in,
  output logic [USS_STAGES-1:0] bus_out
);
  // ==========================================================
  // Wire level
  logic [USS_STAGES-1:0] last_q;
  always_ff @(posedge clk_in) begin
    last_q <= bus_out;
  end
  // Undriven lines flip, so a released bus never passes for a held one
  always_comb begin
    for (int i = 0; i < USS_STAGES; i++) begin
      if (dev_oe_in[i]) bus_out[i] = dev_data_in[i];
      else if (drive_in) bus_out[i] = data_in[i];
      else bus_out[i] = ~last_q[i];
    end
  end
endmodule : uss_bus_partner

// ### uss_shift_register_properties.sv
/*
  Pin-level assertions of the shift register top.
  Assumes soft clear is seen by following the write channel ports.
*/
`timescale 1ns/1ps
module uss_checker
  import uss_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic shift_clock_in,
  input wire logic master_reset_n_in,
  input wire logic mode_select_hi_in,
  input wire logic mode_select_lo_in,
  input wire logic right_serial_in,
  input wire logic left_serial_in,
  input wire logic output_enable_a_n_in,
  input wire logic output_enable_b_n_in,
  input wire logic [USS_STAGES-1:0] parallel_bus_in,
  input wire logic [USS_STAGES-1:0] parallel_bus_out,
  input wire logic [USS_STAGES-1:0] parallel_bus_oe_out,
  input wire logic first_stage_tap_out,
  input wire logic last_stage_tap_out,
  input wire logic [USS_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic [USS_DATA_W-1:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out
);
  // ==========================================================
  // Soft clear, rebuilt from the write channel
  logic [USS_ADDR_W-1:0] aw_q;
  logic clr_bit_q;
  logic bvalid_q;
  logic clear_pulse;
  always_ff @(posedge clk_in) begin
    bvalid_q <= s_axi_bvalid_out;
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_q <= s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      clr_bit_q <=
        s_axi_wdata_in[USS_CTRL_SOFT_CLEAR] && s_axi_wstrb_in[0];
    end
  end
  // High in the cycle in which the clear pulse reaches the stages
  assign clear_pulse = s_axi_bvalid_out && !bvalid_q && clr_bit_q &&
    aw_q[USS_ADDR_W-1:2] == USS_OFS_CTRL[USS_ADDR_W-1:2];
  // ==========================================================
  // Shift clock edge, seen as the design samples it
  logic sc_q;
  always_ff @(posedge clk_in) begin
    sc_q <= shift_clock_in;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence step_s(logic hi, logic lo);
    master_reset_n_in && !clear_pulse && shift_clock_in && !sc_q &&
      mode_select_hi_in == hi && mode_select_lo_in == lo;
  endsequence
  sequence quiet_s;
    master_reset_n_in && !clear_pulse && (sc_q || !shift_clock_in ||
      !(mode_select_hi_in || mode_select_lo_in));
  endsequence
  // ==========================================================
  // Stages and drivers
  a_load_copies: assert property (step_s(1'b1, 1'b1) |=>
    !master_reset_n_in || parallel_bus_out == $past(parallel_bus_in))
    else $error("load wrong");
  a_shift_right: assert property (step_s(1'b0, 1'b1) |=>
    !master_reset_n_in || parallel_bus_out ==
    {$past(parallel_bus_out[6:0]), $past(right_serial_in)})
    else $error("right shift wrong");
  a_shift_left: assert property (step_s(1'b1, 1'b0) |=>
    !master_reset_n_in || parallel_bus_out ==
    {$past(left_serial_in), $past(parallel_bus_out[7:1])})
    else $error("left shift wrong");
  a_quiet_stable: assert property (quiet_s |=>
    !master_reset_n_in || $stable(parallel_bus_out))
    else $error("stages changed without an edge");
  a_reset_mask: assert property (!master_reset_n_in |->
    parallel_bus_out == 8'h00 && !first_stage_tap_out && !last_stage_tap_out)
    else $error("reset not seen at once");
  a_reset_clear: assert property (
    !master_reset_n_in ##1 master_reset_n_in |-> parallel_bus_out == 8'h00)
    else $error("stages not cleared");
  a_taps_follow: assert property (master_reset_n_in |->
    {last_stage_tap_out, first_stage_tap_out} ==
    {parallel_bus_out[7], parallel_bus_out[0]})
    else $error("taps wrong");
  a_enable_off: assert property (
    output_enable_a_n_in || output_enable_b_n_in |->
    parallel_bus_oe_out == 8'h00) else $error("bus driven while disabled");
  a_load_release: assert property (
    mode_select_hi_in && mode_select_lo_in |->
    parallel_bus_oe_out == 8'h00) else $error("bus driven in load");
  a_soft_clear: assert property (master_reset_n_in && clear_pulse |=>
    !master_reset_n_in || parallel_bus_out == 8'h00)
    else $error("soft clear missed");
endmodule : uss_checker

bind uss_shift_register uss_checker u_chk (
  .clk_in(clk_in), .srst_in(srst_in), .shift_clock_in(shift_clock_in),
  .master_reset_n_in(master_reset_n_in),
  .mode_select_hi_in(mode_select_hi_in),
  .mode_select_lo_in(mode_select_lo_in),
  .right_serial_in(right_serial_in), .left_serial_in(left_serial_in),
  .output_enable_a_n_in(output_enable_a_n_in),
  .output_enable_b_n_in(output_enable_b_n_in),
  .parallel_bus_in(parallel_bus_in), .parallel_bus_out(parallel_bus_out),
  .parallel_bus_oe_out(parallel_bus_oe_out),
  .first_stage_tap_out(first_stage_tap_out),
  .last_stage_tap_out(last_stage_tap_out),
  .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out), .s_axi_wdata_in(s_axi_wdata_in),
  .s_axi_wstrb_in(s_axi_wstrb_in), .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bvalid_out(s_axi_bvalid_out));

// ### uss_shift_register_test.sv
/*
  Self-checking bench of the shift register top with its bus partner.
  Assumes the checker is bound to the top.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module uss_shift_register_test
  import uss_pkg::*;
;
  logic clk_in = 1'b0, srst_in = 1'b1, sc = 1'b0, mr_n = 1'b1, drv = 1'b0;
  logic s_hi = 1'b0, s_lo = 1'b0, rs = 1'b0, ls = 1'b0, br = 1'b0;
  logic oea_n = 1'b0, oeb_n = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic rr = 1'b0, awr, wr, bv, arr, rv, t0, t7;
  logic [7:0] pdata = 8'h00, awaddr = 8'h00, araddr = 8'h00, bus, bout, boe;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  int errors = 0, checks_done = 0, cyc = 0;
  uss_shift_register u_dut (.clk_in(clk_in), .srst_in(srst_in),
    .shift_clock_in(sc), .master_reset_n_in(mr_n), .mode_select_hi_in(s_hi),
    .mode_select_lo_in(s_lo), .right_serial_in(rs), .left_serial_in(ls),
    .output_enable_a_n_in(oea_n), .output_enable_b_n_in(oeb_n),
    .parallel_bus_in(bus), .parallel_bus_out(bout),
    .parallel_bus_oe_out(boe), .first_stage_tap_out(t0),
    .last_stage_tap_out(t7), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr));
  uss_bus_partner u_bus (.clk_in(clk_in), .dev_data_in(bout),
    .dev_oe_in(boe), .drive_in(drv), .data_in(pdata), .bus_out(bus));
  // ==========================================================
  // Clock, watchdog and shared tasks
  initial forever #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // Shift clock low again before the next rise, as the sampler needs
  task automatic step();
    sc <= 1'b1;
    @(posedge clk_in);
    sc <= 1'b0;
    @(posedge clk_in);
    #1;
  endtask : step
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (bv !== 1'b1);
    rsp = bresp;
    br <= 1'b0;
    #1;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    araddr <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rr <= 1'b0;
    #1;
  endtask : axr
  // ==========================================================
  // Scenarios
  task automatic t_modes();
    s_hi <= 1'b1;
    s_lo <= 1'b1;
    #1;
    `CHK(boe, 8'h00)
    drv <= 1'b1;
    pdata <= 8'hA5;
    step();
    s_hi <= 1'b0;
    drv <= 1'b0;
    rs <= 1'b1;
    oea_n <= 1'b1;
    `CHK(bout, 8'hA5)
    step();
    `CHK(bout, 8'h4B)
    `CHK(boe, 8'h00)
    `CHK({t7, t0}, 2'b01)
    sc <= 1'b1;
    repeat (3) @(posedge clk_in);
    sc <= 1'b0;
    @(posedge clk_in);
    #1;
    `CHK(bout, 8'h97)
    {oea_n, oeb_n, s_hi, s_lo, ls} <= 5'b01101;
    step();
    `CHK({t7, bout, boe}, {1'b1, 8'hCB, 8'h00})
    {oeb_n, s_hi} <= 2'b00;
    step();
    step();
    `CHK({bus, boe}, {8'hCB, 8'hFF})
    $display("mode test done");
  endtask : t_modes
  task automatic t_regs();
    axw(USS_OFS_EDGES, 32'h0);
    step();
    step();
    axr(USS_OFS_EDGES);
    `CHK(rd, 32'h0000_0002)
    axw(USS_OFS_CTRL, 32'h2);
    `CHK({rsp, boe}, {USS_RESP_OKAY, 8'h00})
    axr(USS_OFS_STATE);
    `CHK(rd[9:0], 10'h0CB)
    axw(USS_OFS_CTRL, 32'h0);
    `CHK(boe, 8'hFF)
    axr(8'h0C);
    `CHK({rsp, rd}, {USS_RESP_SLVERR, 32'h0})
    $display("register test done");
  endtask : t_regs
  task automatic t_reset();
    mr_n <= 1'b0;
    s_lo <= 1'b1;
    #1;
    `CHK({t7, t0, bout}, 10'h000)
    step();
    mr_n <= 1'b1;
    #1;
    `CHK(bout, 8'h00)
    step();
    s_lo <= 1'b0;
    `CHK(bout, 8'h01)
    axw(USS_OFS_CTRL, 32'h1);
    `CHK({rsp, bout}, {USS_RESP_OKAY, 8'h00})
    $display("reset test done");
  endtask : t_reset
  initial begin
    repeat (10) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    t_modes();
    t_regs();
    t_reset();
    stop_test();
  end
endmodule : uss_shift_register_test
